// [rtl/trigger_conditioning.sv]
`default_nettype none
`include "trigger_regs.svh"
module trigger_conditioning (
  input  wire logic                     sys_clk_in,   // 100 MHz clock
  input  wire logic                     rstn_in,      // async reset, low
  input  wire trigger_pkg::reg_addr_type addr_in,     // register address
  input  wire trigger_pkg::reg_data_type wdata_in,    // write data
  input  wire logic                     wr_in,        // write strobe
  input  wire logic                     rd_in,        // read strobe
  output var  trigger_pkg::reg_data_type rdata_out,   // read data
  input  wire logic [3:0]               line_in,      // trigger pins
  input  wire logic [7:0]               pkt_byte_in,  // packet byte
  input  wire logic                     pkt_valid_in, // byte valid
  input  wire logic                     pkt_first_in, // first byte
  input  wire logic                     pkt_last_in,  // last byte
  input  wire logic                     pkt_bcast_in, // broadcast packet
  output var  logic                     trig_out,     // trigger pulse
  output var  logic                     ack_req_out,  // acknowledge pulse
  output var  logic [15:0]              ack_id_out    // request id
);
  import trigger_pkg::*;

  localparam logic [11:0] LAT_LAST = 12'(`TRG_LAT_CYC - 1);
  localparam int          LAT_MAXC = `TRG_LAT_MAX_CYC;

  logic [31:0]   ctrl_q, stable_q, dkey_q, gkey_q, gmask_q;
  logic [3:0]    div_q, presc_cnt_q;
  logic [3:0]    sync1_q, sync2_q;
  logic [4:0]    tick_acc_q;
  logic          tick_q;
  logic          deb_lvl, cond_lvl, cond_prev_q, line_edge, presc_fire;
  logic          sel_lvl, div_wr;
  logic [151:0]  pkt_sr_q;
  logic [159:0]  pkt_full;
  logic [4:0]    idx_q;
  logic          pkt_done, len_ok, hdr_ok, match, accept;
  logic          bcast_q, last_bcast_q, last_ack_q;
  net_state_type net_state_q;
  logic [11:0]   net_cnt_q;
  logic          net_fire, ack_pend_q;
  logic [15:0]   id_pend_q, acc_cnt_q, rej_cnt_q;

  //////////////////////////////////////////////////////////////////////////
  // register port

  assign div_wr = wr_in && addr_in == `TRG_ADDR_PRESCALE;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_q   <= `TRG_CTRL_RST;
      stable_q <= `TRG_STABLE_RST;
      div_q    <= `TRG_DIV_RST;
      dkey_q   <= `TRG_KEY_RST;
      gkey_q   <= `TRG_KEY_RST;
      gmask_q  <= `TRG_KEY_RST;
    end else if (wr_in) begin
      case (addr_in)
        `TRG_ADDR_CTRL:     ctrl_q   <= wdata_in;
        `TRG_ADDR_STABLE:   stable_q <= wdata_in;
        `TRG_ADDR_PRESCALE: div_q    <= wdata_in[3:0];
        `TRG_ADDR_DEV_KEY:  dkey_q   <= wdata_in;
        `TRG_ADDR_GRP_KEY:  gkey_q   <= wdata_in;
        `TRG_ADDR_GRP_MASK: gmask_q  <= wdata_in;
        default: ;
      endcase
    end
  end

  // unmapped addresses read as zero
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (rd_in) begin
      case (addr_in)
        `TRG_ADDR_CTRL:     rdata_out <= ctrl_q;
        `TRG_ADDR_STABLE:   rdata_out <= stable_q;
        `TRG_ADDR_PRESCALE: rdata_out <= {28'h0000000, div_q};
        `TRG_ADDR_DEV_KEY:  rdata_out <= dkey_q;
        `TRG_ADDR_GRP_KEY:  rdata_out <= gkey_q;
        `TRG_ADDR_GRP_MASK: rdata_out <= gmask_q;
        `TRG_ADDR_STATUS:   rdata_out <= {24'h000000, presc_cnt_q,
                                          last_ack_q, last_bcast_q,
                                          net_state_q, cond_lvl};
        `TRG_ADDR_COUNTS:   rdata_out <= {rej_cnt_q, acc_cnt_q};
        default:            rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      rdata_out <= 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // line input conditioning

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= line_in;
      sync2_q <= sync1_q;
    end
  end

  // 15 ns units from a 10 ns clock: two ticks every three cycles
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tick_acc_q <= 5'h00;
      tick_q     <= 1'b0;
    end else if (tick_acc_q + 5'(`TRG_SYS_PERIOD_NS)
                 >= 5'(`TRG_TICK_NS)) begin
      tick_acc_q <= tick_acc_q + 5'(`TRG_SYS_PERIOD_NS)
                    - 5'(`TRG_TICK_NS);
      tick_q     <= 1'b1;
    end else begin
      tick_acc_q <= tick_acc_q + 5'(`TRG_SYS_PERIOD_NS);
      tick_q     <= 1'b0;
    end
  end

  assign sel_lvl = sync2_q[ctrl_q[`TRG_CTRL_SRC_HI:`TRG_CTRL_SRC_LO]];

  stable_filter u_filter (
    .sys_clk_in      (sys_clk_in),
    .rstn_in         (rstn_in),
    .tick_in         (tick_q),
    .level_in        (sel_lvl),
    .stable_ticks_in (stable_q),
    .level_out       (deb_lvl)
  );

  // the filter keeps running when bypassed so enabling it is glitch free
  assign cond_lvl  = ctrl_q[`TRG_CTRL_DEB_EN] ? deb_lvl : sel_lvl;
  assign line_edge = cond_lvl && !cond_prev_q;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cond_prev_q <= 1'b0;
    end else begin
      cond_prev_q <= cond_lvl;
    end
  end

  // divisor field d divides by d+1, so 0 passes all and 15 gives 16
  assign presc_fire = line_edge && presc_cnt_q == div_q;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      presc_cnt_q <= 4'h0;
    end else if (div_wr) begin
      presc_cnt_q <= 4'h0;
    end else if (presc_fire) begin
      presc_cnt_q <= 4'h0;
    end else if (line_edge) begin
      presc_cnt_q <= presc_cnt_q + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // network trigger packets

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pkt_sr_q <= '0;
      idx_q    <= 5'h00;
      bcast_q  <= 1'b0;
    end else if (pkt_valid_in) begin
      pkt_sr_q <= pkt_full[151:0];
      if (pkt_first_in) begin
        idx_q   <= 5'h01;
        bcast_q <= pkt_bcast_in;
      end else if (idx_q <= 5'(`TRG_PKT_BYTES)) begin
        idx_q <= idx_q + 5'h01;
      end
    end
  end

  always_comb begin
    pkt_full = {pkt_sr_q, pkt_byte_in};
    pkt_done = pkt_valid_in && pkt_last_in;
    len_ok   = (pkt_first_in ? 5'h00 : idx_q)
               == 5'(`TRG_PKT_BYTES - 1);
    hdr_ok   = len_ok && pkt_full[159:152] == `TRG_PKT_KEY
               && pkt_full[143:128] == `TRG_PKT_CMD
               && pkt_full[127:112] == `TRG_PKT_LEN;
    // unicast and broadcast take the same checks
    match    = hdr_ok && pkt_full[95:64] == dkey_q
               && pkt_full[63:32] == gkey_q
               && |(pkt_full[31:0] & gmask_q);
    // a packet arriving while one is pending is dropped, not queued
    accept   = pkt_done && match && ctrl_q[`TRG_CTRL_NET_EN]
               && net_state_q == NET_IDLE;
  end

  assign net_fire = net_state_q == NET_WAIT && net_cnt_q == LAT_LAST;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      net_state_q <= NET_IDLE;
      net_cnt_q   <= 12'h000;
      ack_pend_q  <= 1'b0;
      id_pend_q   <= 16'h0000;
    end else begin
      case (net_state_q)
        NET_IDLE: begin
          net_cnt_q <= 12'h000;
          if (accept) begin
            net_state_q <= NET_WAIT;
            ack_pend_q  <= pkt_full[151:144] == `TRG_PKT_ACK_FLAG;
            id_pend_q   <= pkt_full[111:96];
          end
        end
        NET_WAIT: begin
          if (net_fire) begin
            net_state_q <= NET_IDLE;
          end
          net_cnt_q <= net_cnt_q + 12'h001;
        end
        default: net_state_q <= NET_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      last_bcast_q <= 1'b0;
      last_ack_q   <= 1'b0;
      acc_cnt_q    <= 16'h0000;
      rej_cnt_q    <= 16'h0000;
    end else if (pkt_done) begin
      if (accept) begin
        last_bcast_q <= bcast_q && !pkt_first_in || pkt_first_in
                        && pkt_bcast_in;
        last_ack_q   <= pkt_full[151:144] == `TRG_PKT_ACK_FLAG;
        acc_cnt_q    <= acc_cnt_q + 16'h0001;
      end else begin
        rej_cnt_q    <= rej_cnt_q + 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // trigger outputs

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      trig_out    <= 1'b0;
      ack_req_out <= 1'b0;
      ack_id_out  <= 16'h0000;
    end else begin
      trig_out    <= net_fire
                     || presc_fire && ctrl_q[`TRG_CTRL_LINE_EN];
      ack_req_out <= net_fire && ack_pend_q;
      if (net_fire && ack_pend_q) begin
        ack_id_out <= id_pend_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  logic [12:0] lat_mon_q;
  logic [4:0]  edge_mon_q;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lat_mon_q  <= 13'h0000;
      edge_mon_q <= 5'h00;
    end else begin
      lat_mon_q  <= accept ? 13'h0000 : lat_mon_q + 13'h0001;
      if (div_wr || presc_fire) begin
        edge_mon_q <= 5'h00;
      end else if (line_edge) begin
        edge_mon_q <= edge_mon_q + 5'h01;
      end
    end
  end

  a_net_latency: assert property (
    net_fire |-> 32'(lat_mon_q) + 32'd1 >= `TRG_LAT_CYC
      && 32'(lat_mon_q) + 32'd1 <= LAT_MAXC)
    else $error("network trigger outside latency window");
  a_key_match: assert property (
    accept |-> pkt_full[95:64] == dkey_q && pkt_full[63:32] == gkey_q
      && (pkt_full[31:0] & gmask_q) != 32'h0000_0000)
    else $error("packet accepted without key and mask match");
  a_mask_reject: assert property (
    pkt_full[31:0] == 32'h0000_000E && gmask_q == 32'h0000_0001
      |-> !match)
    else $error("disjoint group masks matched");
  a_mask_accept: assert property (
    hdr_ok && pkt_full[95:64] == dkey_q && pkt_full[63:32] == gkey_q
      && pkt_full[31:0] == 32'h0000_FFFF && gmask_q == 32'h0000_0800
      |-> match)
    else $error("overlapping group masks rejected");
  a_bad_header: assert property (
    pkt_done && (pkt_full[159:152] != `TRG_PKT_KEY
      || pkt_full[143:128] != `TRG_PKT_CMD
      || pkt_full[127:112] != `TRG_PKT_LEN) |-> !accept)
    else $error("packet with wrong header started a trigger");
  a_ack_flag: assert property (
    accept |=> ack_pend_q == ($past(pkt_full[151:144]) == `TRG_PKT_ACK_FLAG))
    else $error("acknowledge request does not follow the flag byte");
  a_presc_count: assert property (
    presc_fire |-> edge_mon_q == {1'b0, div_q})
    else $error("prescaler fired after wrong pulse count");
  a_presc_restart: assert property (
    div_wr |=> presc_cnt_q == 4'h0 && !trig_out[*1])
    else $error("prescaler count not cleared on divisor write");
  a_src_bypass: assert property (
    !ctrl_q[`TRG_CTRL_DEB_EN] |-> cond_lvl
      == sync2_q[ctrl_q[`TRG_CTRL_SRC_HI:`TRG_CTRL_SRC_LO]])
    else $error("bypassed line not routed directly");
  a_tick_rate: assert property (
    tick_q && $past(tick_q) |=> !tick_q ##1 tick_q)
    else $error("time unit pulses not at 15 ns average");
  a_ack_pulse: assert property (
    ack_req_out |-> $past(net_fire) && $past(ack_pend_q) ##1 !ack_req_out)
    else $error("acknowledge not paired with network trigger");
endmodule : trigger_conditioning
`default_nettype wire

// [shared/trigger_regs.svh]
`ifndef TRIGGER_REGS_SVH
`define TRIGGER_REGS_SVH
// register byte addresses
`define TRG_ADDR_CTRL     8'h00
`define TRG_ADDR_STABLE   8'h04
`define TRG_ADDR_PRESCALE 8'h08
`define TRG_ADDR_DEV_KEY  8'h0C
`define TRG_ADDR_GRP_KEY  8'h10
`define TRG_ADDR_GRP_MASK 8'h14
`define TRG_ADDR_STATUS   8'h18
`define TRG_ADDR_COUNTS   8'h1C
// control fields
`define TRG_CTRL_DEB_EN   0
`define TRG_CTRL_SRC_LO   2
`define TRG_CTRL_SRC_HI   3
`define TRG_CTRL_LINE_EN  4
`define TRG_CTRL_NET_EN   5
`define TRG_CTRL_RST      32'h0000_0030
`define TRG_STABLE_RST    32'h0001_046A
`define TRG_DIV_RST       4'h0
`define TRG_KEY_RST       32'h0000_0000
// timing
`define TRG_SYS_PERIOD_NS 10
`define TRG_TICK_NS       15
`define TRG_LAT_MIN_NS    25605
`define TRG_LAT_MAX_NS    50130
`define TRG_LAT_CYC \
  ((`TRG_LAT_MIN_NS + `TRG_SYS_PERIOD_NS - 1) / `TRG_SYS_PERIOD_NS)
`define TRG_LAT_MAX_CYC   (`TRG_LAT_MAX_NS / `TRG_SYS_PERIOD_NS)
// packet layout
`define TRG_PKT_KEY       8'h42
`define TRG_PKT_ACK_FLAG  8'h01
`define TRG_PKT_CMD       16'h0100
`define TRG_PKT_LEN       16'h000C
`define TRG_PKT_BYTES     20
`endif

// [shared/trigger_pkg.sv]
`default_nettype none
package trigger_pkg;
  typedef logic [7:0]  reg_addr_type;
  typedef logic [31:0] reg_data_type;
  typedef enum logic [0:0] {
    NET_IDLE = 1'b0,
    NET_WAIT = 1'b1
  } net_state_type;
endpackage : trigger_pkg
`default_nettype wire

// [rtl/stable_filter.sv]
`default_nettype none
module stable_filter (
  input  wire logic        sys_clk_in,      // system clock
  input  wire logic        rstn_in,         // async reset, low
  input  wire logic        tick_in,         // one 15 ns time unit
  input  wire logic        level_in,        // synchronised raw level
  input  wire logic [31:0] stable_ticks_in, // required stable units
  output var  logic        level_out        // accepted level
);
  logic [31:0] cnt_q;

  // any return to the accepted level discards the partial count
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q     <= 32'h0000_0000;
      level_out <= 1'b0;
    end else if (level_in == level_out) begin
      cnt_q <= 32'h0000_0000;
    end else if (cnt_q >= stable_ticks_in) begin
      cnt_q     <= 32'h0000_0000;
      level_out <= level_in;
    end else if (tick_in) begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  a_filter_level: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    $changed(level_out) |-> $past(level_in) == level_out
      && $past(cnt_q) >= $past(stable_ticks_in))
    else $error("filter accepted level without stable count");
endmodule : stable_filter
`default_nettype wire

// [sim/pkt_host.sv]
`default_nettype none
`include "trigger_regs.svh"
module pkt_host (
  input  wire logic       sys_clk_in, // system clock
  output var  logic [7:0] byte_out,   // packet byte
  output var  logic       valid_out,  // byte valid
  output var  logic       first_out,  // first byte
  output var  logic       last_out,   // last byte
  output var  logic       bcast_out   // broadcast packet
);
  timeunit 1ns;
  timeprecision 1ps;
  time last_t; // edge that took the final byte
  initial begin
    byte_out  = 8'h00;
    valid_out = 1'b0;
    first_out = 1'b0;
    last_out  = 1'b0;
    bcast_out = 1'b0;
  end
  task automatic send(input logic [7:0] key, input logic [7:0] flag,
                      input logic [15:0] cmd, input logic [15:0] len,
                      input logic [15:0] id, input logic [31:0] dkey,
                      input logic [31:0] gkey, input logic [31:0] gmask,
                      input logic bc);
    logic [159:0] img;
    img = {key, flag, cmd, len, id, dkey, gkey, gmask};
    for (int i = 0; i < 20; i++) begin
      @(posedge sys_clk_in);
      byte_out  <= img[159-8*i -: 8];
      valid_out <= 1'b1;
      first_out <= (i == 0);
      last_out  <= (i == 19);
      bcast_out <= bc;
    end
    @(posedge sys_clk_in);
    last_t = $time;
    // released bus shows the inverse so a stale byte cannot pass
    byte_out  <= ~img[7:0];
    valid_out <= 1'b0;
    first_out <= 1'b0;
    last_out  <= 1'b0;
    bcast_out <= 1'b0;
  endtask : send
endmodule : pkt_host
`default_nettype wire

// [sim/tb_top.sv]
`default_nettype none
`include "trigger_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import trigger_pkg::*;
  logic         sys_clk_in = 1'b0;
  logic         rstn_in    = 1'b0;
  reg_addr_type addr       = 8'h00;
  reg_data_type wdata      = 32'h0000_0000;
  reg_data_type rdata;
  reg_data_type rd_v;
  logic         wr         = 1'b0;
  logic         rd         = 1'b0;
  logic [3:0]   line       = 4'h0;
  logic [7:0]   pb;
  logic         pv, pf, pl, pbc, trig, ackr;
  logic [15:0]  ack_id;
  int           error_cnt, compares, cyc, trig_cnt, ack_cnt;
  time          trig_t;
  always #5 sys_clk_in = ~sys_clk_in;
  trigger_conditioning uut (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .line_in(line), .pkt_byte_in(pb), .pkt_valid_in(pv),
    .pkt_first_in(pf), .pkt_last_in(pl), .pkt_bcast_in(pbc),
    .trig_out(trig), .ack_req_out(ackr), .ack_id_out(ack_id));
  pkt_host host (
    .sys_clk_in(sys_clk_in), .byte_out(pb), .valid_out(pv),
    .first_out(pf), .last_out(pl), .bcast_out(pbc));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // pulses and acks are counted here; trig_t is one edge past the pulse
  always @(posedge sys_clk_in) begin
    cyc++;
    if (trig === 1'b1) begin
      trig_cnt++;
      trig_t = $time;
    end
    if (ackr === 1'b1) ack_cnt++;
    if (cyc == 60000) begin
      error_cnt++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic wr_reg(input reg_addr_type a, input reg_data_type d);
    @(posedge sys_clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk_in);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input reg_addr_type a);
    @(posedge sys_clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk_in);
    rd   <= 1'b0;
    #1 rd_v = rdata;
  endtask : rd_reg
  task automatic pulse(input int idx, input int hi, input int n);
    repeat (n) begin
      @(posedge sys_clk_in);
      line[idx] <= 1'b1;
      repeat (hi) @(posedge sys_clk_in);
      line[idx] <= 1'b0;
      repeat (hi + 20) @(posedge sys_clk_in);
    end
  endtask : pulse
  task automatic send_ok(input logic [7:0] flag, input logic bc,
                         input logic [31:0] gm);
    host.send(`TRG_PKT_KEY, flag, `TRG_PKT_CMD, `TRG_PKT_LEN, 16'h0A5C,
              32'h0000_AFFE, 32'h0000_1234, gm, bc);
    repeat (2700) @(posedge sys_clk_in);
  endtask : send_ok
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    rd_reg(`TRG_ADDR_CTRL);     chk(rd_v, `TRG_CTRL_RST);
    rd_reg(`TRG_ADDR_STABLE);   chk(rd_v, `TRG_STABLE_RST);
    rd_reg(`TRG_ADDR_PRESCALE); chk(rd_v, 32'h0000_0000);
    wr_reg(`TRG_ADDR_COUNTS, 32'hFFFF_FFFF);
    rd_reg(`TRG_ADDR_COUNTS);   chk(rd_v, 32'h0000_0000);
    rd_reg(8'h20);              chk(rd_v, 32'h0000_0000);
    $display("test registers done");
    pulse(0, 3, 1);             chk(trig_cnt, 1);
    wr_reg(`TRG_ADDR_PRESCALE, 32'h0000_0002);
    pulse(0, 3, 6);             chk(trig_cnt, 3);
    wr_reg(`TRG_ADDR_PRESCALE, 32'h0000_000F);
    pulse(0, 3, 15);            chk(trig_cnt, 3);
    pulse(0, 3, 1);             chk(trig_cnt, 4);
    // a divisor rewrite drops the partial count
    wr_reg(`TRG_ADDR_PRESCALE, 32'h0000_0001);
    pulse(0, 3, 1);
    wr_reg(`TRG_ADDR_PRESCALE, 32'h0000_0001);
    pulse(0, 3, 1);             chk(trig_cnt, 4);
    pulse(0, 3, 1);             chk(trig_cnt, 5);
    $display("test prescaler done");
    wr_reg(`TRG_ADDR_PRESCALE, 32'h0000_0000);
    wr_reg(`TRG_ADDR_STABLE, 32'h0000_000A);
    wr_reg(`TRG_ADDR_CTRL, 32'h0000_0039);
    pulse(0, 40, 1);            chk(trig_cnt, 5);
    pulse(2, 12, 1);            chk(trig_cnt, 5);
    pulse(2, 40, 1);            chk(trig_cnt, 6);
    wr_reg(`TRG_ADDR_CTRL, 32'h0000_0020);
    pulse(0, 3, 1);             chk(trig_cnt, 6);
    $display("test filter done");
    wr_reg(`TRG_ADDR_DEV_KEY, 32'h0000_AFFE);
    wr_reg(`TRG_ADDR_GRP_KEY, 32'h0000_1234);
    wr_reg(`TRG_ADDR_GRP_MASK, 32'h0000_0001);
    host.send(8'h42, 8'h00, 16'h0100, 16'h000C, 16'h0001, 32'h0000_AFFE,
              32'h0000_1234, 32'h0000_000E, 1'b0);
    host.send(8'h41, 8'h00, 16'h0100, 16'h000C, 16'h0001, 32'h0000_AFFE,
              32'h0000_1234, 32'h0000_0001, 1'b0);
    host.send(8'h42, 8'h00, 16'h0101, 16'h000C, 16'h0001, 32'h0000_AFFE,
              32'h0000_1234, 32'h0000_0001, 1'b0);
    host.send(8'h42, 8'h00, 16'h0100, 16'h000D, 16'h0001, 32'h0000_AFFE,
              32'h0000_1234, 32'h0000_0001, 1'b0);
    host.send(8'h42, 8'h00, 16'h0100, 16'h000C, 16'h0001, 32'h0000_AFFF,
              32'h0000_1234, 32'h0000_0001, 1'b1);
    host.send(8'h42, 8'h00, 16'h0100, 16'h000C, 16'h0001, 32'h0000_AFFE,
              32'h0000_0001, 32'h0000_0001, 1'b0);
    repeat (2700) @(posedge sys_clk_in);
    chk(trig_cnt, 6);
    rd_reg(`TRG_ADDR_COUNTS);   chk(rd_v, 32'h0006_0000);
    wr_reg(`TRG_ADDR_GRP_MASK, 32'h0000_0800);
    send_ok(`TRG_PKT_ACK_FLAG, 1'b0, 32'h0000_FFFF);
    chk(trig_cnt, 7);
    chk(ack_cnt, 1);
    chk(ack_id, 16'h0A5C);
    chk((trig_t - host.last_t - 10) >= `TRG_LAT_MIN_NS, 1);
    chk((trig_t - host.last_t - 10) <= `TRG_LAT_MAX_NS, 1);
    rd_reg(`TRG_ADDR_STATUS);   chk(rd_v, 32'h0000_0008);
    send_ok(8'h00, 1'b1, 32'h7FFF_FFFF);
    chk(trig_cnt, 8);
    chk(ack_cnt, 1);
    rd_reg(`TRG_ADDR_COUNTS);   chk(rd_v, 32'h0006_0002);
    rd_reg(`TRG_ADDR_STATUS);   chk(rd_v, 32'h0000_0004);
    $display("test network done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
